// ---- loop_clock_ctrl.v ----
// Purpose: Loop bandwidth control, lock detection and base clock selection
// Assumes: Crystal and VCO clocks are slower than half of clk_i
// Notes:   Source clocks are sampled, so base_clock_out_o is clk_i aligned
//          Lock detector counts feedback pulses per window of crystal edges
//          Offsets, fields and counts live in the regs header
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "loop_clock_regs.vh"

module loop_clock_ctrl #(
	parameter [7:0] WINDOW = `DET_WINDOW
) (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       crystal_clock_i,
	input  wire       vco_clock_i,
	input  wire       stop_i,
	input  wire [1:0] addr_i,
	input  wire [7:0] wr_data_i,
	input  wire       wr_i,
	input  wire       rd_i,
	output reg  [7:0] rd_data_o,
	output reg        base_clock_out_o,
	output reg        vco_enable_o,
	output reg        filter_track_o,
	output reg        vco_feedback_clock_o,
	output reg        irq_o
);

	// ======================================================================
	// Helpers
	function [3:0] eff_mult;
		input [3:0] n;
		begin
			eff_mult = (n == 4'h0) ? 4'h1 : n;
		end
	endfunction

	function [7:0] abs_diff;
		input [7:0] a;
		input [7:0] b;
		begin
			abs_diff = (a > b) ? (a - b) : (b - a);
		end
	endfunction

	// One-hot states of the source switch
	localparam [1:0] ST_RUN  = 2'b01;
	localparam [1:0] ST_HOLD = 2'b10;

	// ======================================================================
	// Source clock synchronisers
	reg  [1:0] sync1_reg;
	reg  [1:0] sync2_reg;
	reg  [1:0] sync3_reg;
	wire [1:0] src_raw = {vco_clock_i, crystal_clock_i};
	wire [1:0] src_rise = sync2_reg & ~sync3_reg;
	wire       xtal_rise = src_rise[0];
	wire       vco_rise = src_rise[1];

	// The second and third flops feed the edge detect; the third is the second's delayed copy
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			always @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
					sync3_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= src_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					sync3_reg[gi] <= sync2_reg[gi];
				end
			end
		end
	endgenerate

	// ======================================================================
	// Registers
	reg  [7:0] prog_reg;
	reg        ie_reg;
	reg        flag_reg;
	reg        on_reg;
	reg        bss_reg;
	reg        auto_reg;
	reg        track_reg;
	reg        lock_reg;

	wire [3:0] mult_n = prog_reg[7:4];
	wire [3:0] range_l = prog_reg[3:0];
	wire       loop_run = on_reg && (range_l != 4'h0);
	wire       wr_ctl = wr_i && (addr_i == `OFS_LOOP_CONTROL);
	wire       wr_bw = wr_i && (addr_i == `OFS_BANDWIDTH);
	wire       wr_pg = wr_i && (addr_i == `OFS_MULT_PROGRAM);
	wire       rd_ctl = rd_i && (addr_i == `OFS_LOOP_CONTROL);
	wire       new_on = wr_data_i[`CTL_ON_BIT];
	wire       new_bss = wr_data_i[`CTL_BSS_BIT];
	wire       both_chg = (new_on != on_reg) && (new_bss != bss_reg);
	wire       lock_toggle;
	wire       auto_track_next;

	reg on_next;
	reg bss_next;
	always @* begin
		on_next = on_reg;
		bss_next = bss_reg;
		if (wr_ctl && !both_chg) begin
			if (new_on || !bss_reg)
				on_next = new_on;
			if (!new_bss || (on_reg && range_l != 4'h0))
				bss_next = new_bss;
		end
		if (stop_i)
			bss_next = 1'b0;
	end

	// Program register, no side effects
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			prog_reg <= `MULT_PROGRAM_RST;
		else if (wr_pg)
			prog_reg <= wr_data_i;
	end

	// Loop enable and source select, guarded above
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			on_reg <= `LOOP_ON_RST;
			bss_reg <= 1'b0;
		end else begin
			on_reg <= on_next;
			bss_reg <= bss_next;
		end
	end

	// Enable only writable in auto mode, forced low in manual
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			ie_reg <= 1'b0;
		else if (!auto_reg)
			ie_reg <= 1'b0;
		else if (wr_ctl)
			ie_reg <= wr_data_i[`CTL_IE_BIT];
	end

	// Set wins over a same-cycle read so no lock change is lost
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			flag_reg <= 1'b0;
		else if (auto_reg && lock_toggle)
			flag_reg <= 1'b1;
		else if (rd_ctl || !auto_reg)
			flag_reg <= 1'b0;
	end

	// Bandwidth mode select
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			auto_reg <= 1'b0;
		else if (wr_bw)
			auto_reg <= wr_data_i[`BW_AUTO_BIT];
	end

	// Tracking bit: detector owned in auto, software owned in manual
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			track_reg <= 1'b0;
		else if (auto_reg)
			track_reg <= auto_track_next;
		else if (wr_bw)
			track_reg <= wr_data_i[`BW_TRACK_BIT];
	end

	// ======================================================================
	// Feedback divider and lock detector
	reg  [3:0] div_cnt_reg;
	reg        fb_pulse_reg;
	reg  [7:0] ref_cnt_reg;
	reg  [7:0] fb_cnt_reg;
	reg        det_track_reg;
	wire       win_end = xtal_rise && (ref_cnt_reg == WINDOW - 8'h0_1);
	wire [7:0] err = abs_diff(fb_cnt_reg, WINDOW);
	reg        lock_next;
	reg        dtrk_next;

	// Hysteresis: looser exit tolerance keeps the flags from chattering
	always @* begin
		lock_next = lock_reg;
		dtrk_next = det_track_reg;
		if (!loop_run || !auto_reg) begin
			lock_next = 1'b0;
			dtrk_next = 1'b0;
		end else if (win_end) begin
			if (err <= `TOL_LOCK)
				lock_next = 1'b1;
			else if (err > `TOL_UNLOCK)
				lock_next = 1'b0;
			if (err <= `TOL_TRACK)
				dtrk_next = 1'b1;
			else if (err > `TOL_UNTRACK)
				dtrk_next = 1'b0;
		end
	end

	assign lock_toggle = (lock_next != lock_reg);
	assign auto_track_next = dtrk_next;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt_reg <= 4'h0;
			fb_pulse_reg <= 1'b0;
			ref_cnt_reg <= 8'h0_0;
			fb_cnt_reg <= 8'h0_0;
			det_track_reg <= 1'b0;
			lock_reg <= 1'b0;
		end else begin
			det_track_reg <= dtrk_next;
			lock_reg <= lock_next;
			fb_pulse_reg <= 1'b0;
			if (!loop_run) begin
				div_cnt_reg <= 4'h0;
			end else if (vco_rise) begin
				if (div_cnt_reg >= eff_mult(mult_n) - 4'h1) begin
					div_cnt_reg <= 4'h0;
					fb_pulse_reg <= 1'b1;
				end else begin
					div_cnt_reg <= div_cnt_reg + 4'h1;
				end
			end
			if (!loop_run || win_end) begin
				ref_cnt_reg <= 8'h0_0;
				fb_cnt_reg <= 8'h0_0;
			end else begin
				if (xtal_rise)
					ref_cnt_reg <= ref_cnt_reg + 8'h0_1;
				if (fb_pulse_reg && fb_cnt_reg != 8'hF_F)
					fb_cnt_reg <= fb_cnt_reg + 8'h0_1;
			end
		end
	end

	// ======================================================================
	// Glitch-free base clock selector
	reg  [1:0] st_reg;
	reg        cur_vco_reg;
	reg  [1:0] xcnt_reg;
	reg  [1:0] vcnt_reg;
	// Range zero forces the crystal even with the select bit set
	wire       want_vco = bss_reg && loop_run;
	wire       cur_rise = cur_vco_reg ? vco_rise : xtal_rise;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= ST_RUN;
			cur_vco_reg <= 1'b0;
			xcnt_reg <= 2'h0;
			vcnt_reg <= 2'h0;
			base_clock_out_o <= 1'b0;
		end else begin
			case (st_reg)
			ST_RUN: begin
				if (cur_rise)
					base_clock_out_o <= ~base_clock_out_o;
				if (want_vco != cur_vco_reg) begin
					st_reg <= ST_HOLD;
					xcnt_reg <= 2'h0;
					vcnt_reg <= 2'h0;
				end
			end
			ST_HOLD: begin
				// Output frozen; a stopped VCO blocks the return unless the loop is off
				if (xtal_rise && xcnt_reg != `SWITCH_EDGES)
					xcnt_reg <= xcnt_reg + 2'h1;
				if (vco_rise && vcnt_reg != `SWITCH_EDGES)
					vcnt_reg <= vcnt_reg + 2'h1;
				if (xcnt_reg == `SWITCH_EDGES &&
				    (vcnt_reg == `SWITCH_EDGES || !loop_run)) begin
					cur_vco_reg <= want_vco;
					st_reg <= ST_RUN;
				end
			end
			default: st_reg <= ST_RUN;
			endcase
		end
	end

	// ======================================================================
	// Outputs
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			vco_enable_o <= 1'b0;
		else
			vco_enable_o <= loop_run;
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			filter_track_o <= 1'b0;
		else
			filter_track_o <= track_reg;
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			vco_feedback_clock_o <= 1'b0;
		else if (fb_pulse_reg)
			vco_feedback_clock_o <= ~vco_feedback_clock_o;
	end

	// Level request; cleared through the flag, the enable or leaving auto
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= auto_reg && ie_reg && flag_reg;
	end

	// ======================================================================
	// Read port
	// Lock masked by auto: lock_reg clears one cycle after leaving auto
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= 8'h0_0;
		end else begin
			rd_data_o <= 8'h0_0;
			if (rd_i) begin
				case (addr_i)
				`OFS_LOOP_CONTROL:
					rd_data_o <= {ie_reg, flag_reg, on_reg, bss_reg,
					              4'h0} | `CTL_UNUSED_MASK;
				`OFS_BANDWIDTH:
					rd_data_o <= {auto_reg, auto_reg && lock_reg,
					              track_reg, 5'h00};
				`OFS_MULT_PROGRAM:
					rd_data_o <= prog_reg;
				default:
					rd_data_o <= 8'h0_0;
				endcase
			end
		end
	end

endmodule // loop_clock_ctrl

// ---- loop_clock_regs.vh ----
// Purpose: Offsets, fields, reset values and counts of the loop clock block
// Assumes: 8-bit register port, byte offsets
// Notes:   Included by loop_clock_ctrl.v only
`ifndef LOOP_CLOCK_REGS_VH
`define LOOP_CLOCK_REGS_VH

// ==========================================================================
// Offsets
`define OFS_LOOP_CONTROL   2'h0
`define OFS_BANDWIDTH      2'h1
`define OFS_MULT_PROGRAM   2'h2

// ==========================================================================
// Loop control register fields
`define CTL_IE_BIT         7
`define CTL_FLAG_BIT       6
`define CTL_ON_BIT         5
`define CTL_BSS_BIT        4
`define CTL_UNUSED_MASK    8'h0F

// ==========================================================================
// Bandwidth register fields
`define BW_AUTO_BIT        7
`define BW_LOCK_BIT        6
`define BW_TRACK_BIT       5

// ==========================================================================
// Reset values
`define MULT_PROGRAM_RST   8'h1_1
`define LOOP_ON_RST        1'b1

// ==========================================================================
// Lock detector and switch counts
`define DET_WINDOW         8'h1_0
`define TOL_TRACK          8'h0_1
`define TOL_UNTRACK        8'h0_2
`define TOL_LOCK           8'h0_0
`define TOL_UNLOCK         8'h0_1
`define SWITCH_EDGES       2'h3

`endif

// ---- loop_clock_ctrl_asserts.sv ----
// Purpose: Port level checks of the loop clock block
// Assumes: Single clk_i domain, rst_i async active high
// Notes:   Program register shadowed from the write port
`timescale 1ns/1ps
module loop_clock_ctrl_asserts #(
	parameter [7:0] WINDOW = 8'h10
) (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       stop_i,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rd_data_o,
	input wire logic       base_clock_out_o,
	input wire logic       vco_enable_o,
	input wire logic       filter_track_o
);
	// ==========================================================
	// Shadow of the program register
	logic [7:0] prog_reg;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) prog_reg <= 8'h11;
		else if (wr_i && addr_i == 2'h2) prog_reg <= wr_data_i;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// Properties
	property p_rd_idle;
		!$past(rd_i) |-> rd_data_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside its slot");
	property p_prog;
		rd_i && addr_i == 2'h2 |=> rd_data_o == $past(prog_reg);
	endproperty
	a_prog: assert property (p_prog)
		else $error("program readback wrong");
	property p_track;
		rd_i && addr_i == 2'h1 |=> rd_data_o[5] == filter_track_o;
	endproperty
	a_track: assert property (p_track)
		else $error("track bit and filter mode differ");
	property p_lock_man;
		rd_i && addr_i == 2'h1 |=> !(rd_data_o[6] && !rd_data_o[7]);
	endproperty
	a_lock_man: assert property (p_lock_man)
		else $error("lock seen in manual mode");
	property p_bss_on;
		rd_i && addr_i == 2'h0 |=> !(rd_data_o[4] && !rd_data_o[5]);
	endproperty
	a_bss_on: assert property (p_bss_on)
		else $error("vco selected with loop off");
	property p_stop;
		$past(stop_i) && rd_i && addr_i == 2'h0 |=> !rd_data_o[4];
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop left vco selected");
	property p_range0;
		prog_reg[3:0] == 4'h0 |=> !vco_enable_o;
	endproperty
	a_range0: assert property (p_range0)
		else $error("loop on with range zero");
	property p_half;
		$changed(base_clock_out_o) |=> $stable(base_clock_out_o);
	endproperty
	a_half: assert property (p_half)
		else $error("base clock toggled twice in a row");
	c_auto: cover property (rd_i && addr_i == 2'h1 ##1 rd_data_o[7]);
	c_base: cover property ($rose(base_clock_out_o));
	c_vco: cover property ($rose(vco_enable_o));
endmodule // loop_clock_ctrl_asserts
bind loop_clock_ctrl loop_clock_ctrl_asserts #(.WINDOW(WINDOW)) i_chk (
	.clk_i(clk_i), .rst_i(rst_i), .stop_i(stop_i), .addr_i(addr_i),
	.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
	.rd_data_o(rd_data_o), .base_clock_out_o(base_clock_out_o),
	.vco_enable_o(vco_enable_o), .filter_track_o(filter_track_o));

// ---- loop_clock_ctrl_tb.sv ----
// Purpose: Self-checking bench of the loop clock block
// Assumes: Crystal 10 clk period, small lock window
// Notes:   Source clocks free running, phase unrelated
`timescale 1ns/1ps
module loop_clock_ctrl_tb;
	logic       clk_i, rst_i, crystal_clock_i, vco_clock_i, stop_i;
	logic [1:0] addr_i;
	logic [7:0] wr_data_i, rd_data_o, d, v;
	logic       wr_i, rd_i, base_clock_out_o, vco_enable_o;
	logic       filter_track_o, vco_feedback_clock_o, irq_o;
	int         mismatches, checks_done, vco_half, c;
	logic [31:0] seed = 32'h0000_0053;
	loop_clock_ctrl #(.WINDOW(8'h04)) i_dut (.clk_i(clk_i),
		.rst_i(rst_i), .crystal_clock_i(crystal_clock_i),
		.vco_clock_i(vco_clock_i), .stop_i(stop_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
		.rd_data_o(rd_data_o), .base_clock_out_o(base_clock_out_o),
		.vco_enable_o(vco_enable_o), .filter_track_o(filter_track_o),
		.vco_feedback_clock_o(vco_feedback_clock_o), .irq_o(irq_o));
	// ==========================================================
	// Clocks
	initial begin
		clk_i = 0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		crystal_clock_i = 0;
		forever #40 crystal_clock_i = ~crystal_clock_i;
	end
	initial begin
		vco_half = 40;
		vco_clock_i = 0;
		#13;
		forever #(vco_half) vco_clock_i = ~vco_clock_i;
	end
	// ==========================================================
	// Helpers
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function logic in_band(int n, int e);
		return n >= e - 2 && n <= e + 2;
	endfunction
	task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] x);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= x;
		wr_i <= 1;
		@(posedge clk_i);
		wr_i <= 0;
	endtask
	task rd(input logic [1:0] a, input logic [7:0] e, input string nm);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1;
		@(posedge clk_i);
		rd_i <= 0;
		#1 chk(nm, rd_data_o, e);
	endtask
	// Toggles of the base clock over a fixed span
	task count(input int n);
		logic p;
		c = 0;
		p = base_clock_out_o;
		repeat (n) begin
			@(posedge clk_i);
			if (base_clock_out_o !== p) c++;
			p = base_clock_out_o;
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#400_000;
		mismatches++;
		test_done;
	end
	// ==========================================================
	// Main sequence
	initial begin
		rst_i = 1;
		stop_i = 0;
		addr_i = 0;
		wr_data_i = 0;
		wr_i = 0;
		rd_i = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		rd(0, 8'h2F, "ctl rst");
		rd(1, 8'h00, "bw rst");
		rd(2, 8'h11, "prog rst");
		rd(3, 8'h00, "unmapped");
		wr(0, 8'h30);
		rd(0, 8'h3F, "bss set");
		wr(0, 8'h10);
		rd(0, 8'h3F, "on kept");
		wr(0, 8'h20);
		wr(0, 8'h00);
		wr(0, 8'h10);
		rd(0, 8'h0F, "bss refused");
		wr(0, 8'h30);
		rd(0, 8'h0F, "both change");
		wr(0, 8'h20);
		repeat (4) begin
			v = xs();
			wr(2, v);
			rd(2, v, "prog rand");
		end
		wr(2, 8'h10);
		repeat (3) @(posedge clk_i);
		chk("vco en L0", vco_enable_o, 0);
		wr(0, 8'h30);
		rd(0, 8'h2F, "bss L0");
		wr(2, 8'h11);
		repeat (3) @(posedge clk_i);
		chk("vco en", vco_enable_o, 1);
		wr(1, 8'h20);
		rd(1, 8'h20, "manual trk");
		chk("filter", filter_track_o, 1);
		wr(1, 8'h00);
		wr(0, 8'hA0);
		rd(0, 8'h2F, "ie manual");
		wr(1, 8'h80);
		repeat (200) @(posedge clk_i);
		wr(1, 8'h80);
		rd(1, 8'hE0, "auto lock");
		rd(0, 8'h6F, "flag");
		rd(0, 8'h2F, "flag clr");
		wr(0, 8'hA0);
		vco_half = 400;
		repeat (300) @(posedge clk_i);
		chk("irq", irq_o, 1);
		rd(1, 8'h80, "unlock");
		rd(0, 8'hEF, "flag2");
		repeat (3) @(posedge clk_i);
		chk("irq clr", irq_o, 0);
		count(400);
		chk("xtal div", in_band(c, 40), 1);
		vco_half = 56;
		wr(0, 8'hB0);
		repeat (150) @(posedge clk_i);
		count(400);
		chk("vco div", in_band(c, 28), 1);
		@(posedge clk_i);
		stop_i <= 1;
		@(posedge clk_i);
		stop_i <= 0;
		rd(0, 8'hAF, "stop");
		test_done;
	end
endmodule // loop_clock_ctrl_tb
